// ---- fbu_pkg.sv ----
// constants for the flash security and margin command block
package fbu_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_PARAM_INDEX = 8'h04;
    localparam logic [7:0] OFS_PARAM_WORD = 8'h08;
    localparam logic [7:0] OFS_SECURITY = 8'h0C;
    localparam logic [7:0] OFS_PROTECTION = 8'h10;
    localparam logic [7:0] OFS_MARGIN = 8'h14;

    // status register fields
    localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
    localparam int STAT_ACCESS_ERROR_FLAG_BIT = 5;
    localparam int STAT_PROTECTION_VIOLATION_FLAG_BIT = 4;

    // security byte fields
    localparam int SEC_BACKDOOR_KEY_ENABLE_LSB = 6;
    localparam int SEC_STATE_LSB = 0;
    localparam logic [1:0] BACKDOOR_KEY_ENABLE_ENABLED = 2'h2;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;

    // margin status register fields
    localparam int MARG_PF_LSB = 0;
    localparam int MARG_EE_LSB = 4;
    localparam int MARG_LOCK_BIT = 8;
    localparam int MARG_BUSY_BIT = 9;

    // reset values
    localparam logic [7:0] PROT_RESET = 8'hFF;
    localparam logic [7:0] SEC_RESET = 8'hFE;
    localparam logic [2:0] MARGIN_NORMAL = 3'h0;

    // command opcodes carried in param word 0 bits 15:8
    localparam logic [7:0] OP_PROGRAM_CFG = 8'h06;
    localparam logic [7:0] OP_ERASE_CFG = 8'h0A;
    localparam logic [7:0] OP_VERIFY_KEY = 8'h0C;
    localparam logic [7:0] OP_USER_MARGIN = 8'h0D;
    localparam logic [7:0] OP_FIELD_MARGIN = 8'h0E;

    // margin codes
    localparam logic [15:0] MC_USER_MAX = 16'h0002;
    localparam logic [15:0] MC_FIELD_MAX = 16'h0004;

    // block select codes
    localparam logic [1:0] BLK_PFLASH = 2'h0;
    localparam logic [1:0] BLK_EEPROM = 2'h1;

    // required last parameter index per command
    localparam logic [2:0] IDX_MARGIN = 3'h1;
    localparam logic [2:0] IDX_VERIFY = 3'h4;
    localparam logic [2:0] IDX_CFG = 3'h1;

    // parameter bank depth and key geometry
    localparam int PARAM_DEPTH = 6;
    localparam int KEY_WORDS = 4;
    localparam logic [15:0] KEY_ZERO = 16'h0000;
    localparam logic [15:0] KEY_ONES = 16'hFFFF;

    // key compare takes one cycle per key word
    localparam logic [2:0] VERIFY_CYCLES = 3'h4;

    typedef enum logic [1:0] {ST_IDLE, ST_VERIFY, ST_EXEC} fbu_state_t;

endpackage : fbu_pkg

// ---- fbu_flash_sec.sv ----
// flash command controller: backdoor key unlock and read margin commands
// Operation
// - unlock only while key enable field enabled
// - good key: unsecure, security state forced 10
// - bad key blocks all later verify attempts
// - only reset clears the verify lockout
// - nonvolatile security byte left unmodified
// - stored backdoor key words left unmodified
// - protection register untouched by unlock
// - unsecured: security sector erase/program allowed
// - user margin codes 0, 1, 2
// - field margin codes 0 through 4
// - field margin only in special modes
// - field margin applied on the same edge the completion flag is set
// - user margin: eeprom alone, pflash both
// - field margin: eeprom alone, pflash both
// - margin command index not 001: access error
// - invalid block select code: access error
// - invalid margin code: access error
// - during key verify reads return invalid data
// - all-zero and all-one keys rejected
//
// The plain strobed port and the register addresses were chosen for this implementation.
module fbu_flash_sec (
    input wire logic sys_clk, // 200 MHz bus clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [15:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, cycle after strobe
    input wire logic special_mode, // chip in special operating mode
    input wire logic [7:0] nv_security_byte, // stored security byte
    input wire logic [63:0] nv_backdoor_keys, // stored keys, word 0 low
    output logic [1:0] security_state, // runtime security state
    output logic unsecured, // chip currently unsecured
    output logic read_data_invalid, // flash and eeprom reads invalid
    output logic [2:0] pflash_margin, // margin for pflash reads
    output logic [2:0] eeprom_margin, // margin for eeprom reads
    output logic cfg_op_req, // security sector operation pulse
    output logic cfg_op_erase, // 1 erase, 0 program
    output logic [15:0] cfg_op_data // program data for security byte
);

    fbu_pkg::fbu_state_t state_q;
    logic command_complete_flag_q, access_error_flag_q, protection_violation_flag_q;
    logic [2:0] param_index_q;
    logic [15:0] param_word_q [fbu_pkg::PARAM_DEPTH];
    logic [7:0] protection_q, sec_byte_q;
    logic sec_loaded_q, lockout_q, key_bad_q;
    logic [1:0] sec_state_q;
    logic [2:0] verify_cnt_q;
    logic [2:0] pf_margin_q, ee_margin_q;
    logic cfg_req_q, cfg_erase_q;
    logic [15:0] cfg_data_q, rdata_q;

    logic launch, wr_status, set_access_error_flag, margin_err, start_err;
    logic start_verify, start_cfg, cfg_viol, verify_done, verify_ok;
    logic key_mismatch;
    logic [7:0] opcode;
    logic [1:0] blk_code;
    logic [15:0] margin_code;

    // decode of one write-address match
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign opcode = param_word_q[0][15:8];
    assign blk_code = param_word_q[0][1:0];
    assign margin_code = param_word_q[1];
    assign wr_status = reg_wr && hit(reg_addr, fbu_pkg::OFS_STATUS);
    assign launch = wr_status && reg_wdata[fbu_pkg::STAT_COMMAND_COMPLETE_FLAG_BIT]
        && command_complete_flag_q && !access_error_flag_q && !protection_violation_flag_q;

    // launch checks for the margin commands
    always_comb begin
        margin_err = 1'b0;
        if (param_index_q != fbu_pkg::IDX_MARGIN) begin
            margin_err = 1'b1;
        end
        if (blk_code != fbu_pkg::BLK_PFLASH
            && blk_code != fbu_pkg::BLK_EEPROM) begin
            margin_err = 1'b1;
        end
        if (opcode == fbu_pkg::OP_USER_MARGIN
            && margin_code > fbu_pkg::MC_USER_MAX) begin
            margin_err = 1'b1;
        end
        if (opcode == fbu_pkg::OP_FIELD_MARGIN) begin
            if (margin_code > fbu_pkg::MC_FIELD_MAX) begin
                margin_err = 1'b1;
            end
            if (!special_mode) begin
                margin_err = 1'b1;
            end
        end
    end

    // launch-time classification of every opcode
    always_comb begin
        start_err = 1'b0;
        start_verify = 1'b0;
        start_cfg = 1'b0;
        cfg_viol = 1'b0;
        unique case (opcode)
            fbu_pkg::OP_USER_MARGIN, fbu_pkg::OP_FIELD_MARGIN: begin
                start_err = margin_err;
            end
            fbu_pkg::OP_VERIFY_KEY: begin
                if (lockout_q) begin
                    start_err = 1'b1;
                end else if (sec_byte_q[fbu_pkg::SEC_BACKDOOR_KEY_ENABLE_LSB +: 2]
                    != fbu_pkg::BACKDOOR_KEY_ENABLE_ENABLED) begin
                    start_err = 1'b1;
                end else if (param_index_q != fbu_pkg::IDX_VERIFY) begin
                    start_err = 1'b1;
                end else begin
                    start_verify = 1'b1;
                end
            end
            fbu_pkg::OP_ERASE_CFG, fbu_pkg::OP_PROGRAM_CFG: begin
                if (param_index_q != fbu_pkg::IDX_CFG) begin
                    start_err = 1'b1;
                end else if (sec_state_q != fbu_pkg::SEC_UNSECURED) begin
                    cfg_viol = 1'b1;
                end else begin
                    start_cfg = 1'b1;
                end
            end
            default: begin
                start_err = 1'b1;
            end
        endcase
    end

    // one key word compared per cycle; zero and ones never match
    always_comb begin
        key_mismatch = 1'b0;
        for (int i = 0; i < fbu_pkg::KEY_WORDS; i++) begin
            if (verify_cnt_q == 3'(i)) begin
                key_mismatch = (param_word_q[i + 1]
                    != nv_backdoor_keys[i*16 +: 16])
                    || nv_backdoor_keys[i*16 +: 16] == fbu_pkg::KEY_ZERO
                    || nv_backdoor_keys[i*16 +: 16] == fbu_pkg::KEY_ONES;
            end
        end
    end

    assign verify_done = (state_q == fbu_pkg::ST_VERIFY)
        && (verify_cnt_q == fbu_pkg::VERIFY_CYCLES - 3'h1);
    assign verify_ok = verify_done && !key_bad_q && !key_mismatch;
    assign set_access_error_flag = launch && start_err;

    // command sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= fbu_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                fbu_pkg::ST_IDLE: begin
                    if (launch && start_verify) begin
                        state_q <= fbu_pkg::ST_VERIFY;
                    end else if (launch && !start_err && !cfg_viol) begin
                        state_q <= fbu_pkg::ST_EXEC;
                    end
                end
                fbu_pkg::ST_VERIFY: begin
                    if (verify_done) begin
                        state_q <= fbu_pkg::ST_IDLE;
                    end
                end
                fbu_pkg::ST_EXEC: begin
                    state_q <= fbu_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // command complete flag: low while a command runs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            command_complete_flag_q <= 1'b1;
        end else if (launch && start_verify) begin
            command_complete_flag_q <= 1'b0;
        end else if (launch && !start_err && !cfg_viol) begin
            command_complete_flag_q <= 1'b0;
        end else if (verify_done || state_q == fbu_pkg::ST_EXEC) begin
            command_complete_flag_q <= 1'b1;
        end
    end

    // error flags: write one clears, a new error wins over the clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            access_error_flag_q <= 1'b0;
            protection_violation_flag_q <= 1'b0;
        end else begin
            if (set_access_error_flag || (verify_done && !verify_ok)) begin
                access_error_flag_q <= 1'b1;
            end else if (wr_status
                && reg_wdata[fbu_pkg::STAT_ACCESS_ERROR_FLAG_BIT]) begin
                access_error_flag_q <= 1'b0;
            end
            if (launch && cfg_viol) begin
                protection_violation_flag_q <= 1'b1;
            end else if (wr_status
                && reg_wdata[fbu_pkg::STAT_PROTECTION_VIOLATION_FLAG_BIT]) begin
                protection_violation_flag_q <= 1'b0;
            end
        end
    end

    // parameter index and bank, frozen while a command runs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            param_index_q <= 3'h0;
            for (int i = 0; i < fbu_pkg::PARAM_DEPTH; i++) begin
                param_word_q[i] <= 16'h0000;
            end
        end else if (command_complete_flag_q && reg_wr) begin
            if (hit(reg_addr, fbu_pkg::OFS_PARAM_INDEX)) begin
                param_index_q <= reg_wdata[2:0];
            end
            if (hit(reg_addr, fbu_pkg::OFS_PARAM_WORD)
                && param_index_q < 3'(fbu_pkg::PARAM_DEPTH)) begin
                param_word_q[param_index_q] <= reg_wdata;
            end
        end
    end

    // protection register: software only, unlock never writes it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            protection_q <= fbu_pkg::PROT_RESET;
        end else if (reg_wr && hit(reg_addr, fbu_pkg::OFS_PROTECTION)) begin
            protection_q <= reg_wdata[7:0];
        end
    end

    // security byte copy caught once after reset release, never written
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_byte_q <= fbu_pkg::SEC_RESET;
            sec_loaded_q <= 1'b0;
        end else if (!sec_loaded_q) begin
            sec_byte_q <= nv_security_byte;
            sec_loaded_q <= 1'b1;
        end
    end

    // runtime security state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_state_q <= fbu_pkg::SEC_RESET[1:0];
        end else if (!sec_loaded_q) begin
            sec_state_q <= nv_security_byte[fbu_pkg::SEC_STATE_LSB +: 2];
        end else if (verify_ok) begin
            sec_state_q <= fbu_pkg::SEC_UNSECURED;
        end
    end

    // lockout after a bad key, cleared only by reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockout_q <= 1'b0;
        end else if (verify_done && !verify_ok) begin
            lockout_q <= 1'b1;
        end
    end

    // key compare walk; keys are only read, never written
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            verify_cnt_q <= 3'h0;
            key_bad_q <= 1'b0;
        end else if (state_q != fbu_pkg::ST_VERIFY) begin
            verify_cnt_q <= 3'h0;
            key_bad_q <= 1'b0;
        end else begin
            verify_cnt_q <= verify_cnt_q + 3'h1;
            key_bad_q <= key_bad_q || key_mismatch;
        end
    end

    // margin levels stay until the next margin command or reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pf_margin_q <= fbu_pkg::MARGIN_NORMAL;
            ee_margin_q <= fbu_pkg::MARGIN_NORMAL;
        end else if (state_q == fbu_pkg::ST_EXEC
            && (opcode == fbu_pkg::OP_USER_MARGIN
            || opcode == fbu_pkg::OP_FIELD_MARGIN)) begin
            ee_margin_q <= margin_code[2:0];
            if (blk_code == fbu_pkg::BLK_PFLASH) begin
                pf_margin_q <= margin_code[2:0];
            end
        end
    end

    // security sector operation request toward the array
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_req_q <= 1'b0;
            cfg_erase_q <= 1'b0;
            cfg_data_q <= 16'h0000;
        end else begin
            cfg_req_q <= launch && start_cfg;
            if (launch && start_cfg) begin
                cfg_erase_q <= (opcode == fbu_pkg::OP_ERASE_CFG);
                cfg_data_q <= param_word_q[1];
            end
        end
    end

    // register read path
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            rdata_q <= 16'h0000;
            unique case (reg_addr)
                fbu_pkg::OFS_STATUS: begin
                    rdata_q[fbu_pkg::STAT_COMMAND_COMPLETE_FLAG_BIT] <= command_complete_flag_q;
                    rdata_q[fbu_pkg::STAT_ACCESS_ERROR_FLAG_BIT] <= access_error_flag_q;
                    rdata_q[fbu_pkg::STAT_PROTECTION_VIOLATION_FLAG_BIT] <= protection_violation_flag_q;
                end
                fbu_pkg::OFS_PARAM_INDEX: begin
                    rdata_q[2:0] <= param_index_q;
                end
                fbu_pkg::OFS_PARAM_WORD: begin
                    if (param_index_q < 3'(fbu_pkg::PARAM_DEPTH)) begin
                        rdata_q <= param_word_q[param_index_q];
                    end
                end
                fbu_pkg::OFS_SECURITY: begin
                    rdata_q[7:0] <= {sec_byte_q[7:2], sec_state_q};
                end
                fbu_pkg::OFS_PROTECTION: begin
                    rdata_q[7:0] <= protection_q;
                end
                fbu_pkg::OFS_MARGIN: begin
                    rdata_q[fbu_pkg::MARG_PF_LSB +: 3] <= pf_margin_q;
                    rdata_q[fbu_pkg::MARG_EE_LSB +: 3] <= ee_margin_q;
                    rdata_q[fbu_pkg::MARG_LOCK_BIT] <= lockout_q;
                    rdata_q[fbu_pkg::MARG_BUSY_BIT] <= !command_complete_flag_q;
                end
                default: begin
                    rdata_q <= 16'h0000;
                end
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign security_state = sec_state_q;
    assign unsecured = (sec_state_q == fbu_pkg::SEC_UNSECURED);
    assign read_data_invalid = (state_q == fbu_pkg::ST_VERIFY);
    assign pflash_margin = pf_margin_q;
    assign eeprom_margin = ee_margin_q;
    assign cfg_op_req = cfg_req_q;
    assign cfg_op_erase = cfg_erase_q;
    assign cfg_op_data = cfg_data_q;

endmodule : fbu_flash_sec

// ---- fbu_flash_sec_monitor.sv ----
// checker for the flash security and margin command block
module fbu_flash_sec_monitor (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [7:0] reg_addr, // address
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic special_mode, // special mode
    input wire logic [1:0] security_state, // security state
    input wire logic unsecured, // unsecured level
    input wire logic read_data_invalid, // verify running
    input wire logic [2:0] pflash_margin, // pflash margin
    input wire logic [2:0] eeprom_margin, // eeprom margin
    input wire logic cfg_op_req // sector op pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic launch;
    assign launch = reg_wr && reg_addr == fbu_pkg::OFS_STATUS && reg_wdata[7];

    chk_unsec_on_verify:
        assert property ($fell(read_data_invalid) |->
            security_state == 2'h2 || $stable(security_state))
        else $error("verify end left a bad security state");
    chk_unlock_after_verify:
        assert property ($rose(unsecured) |->
            $past(read_data_invalid) || $past(read_data_invalid, 2))
        else $error("unsecured without key verify");
    chk_blank_length:
        assert property ($rose(read_data_invalid) |->
            read_data_invalid [*4] ##1 !read_data_invalid)
        else $error("read blanking length wrong");
    chk_margin_cause:
        assert property ($changed(pflash_margin) || $changed(eeprom_margin)
            |-> $past(launch, 2))
        else $error("margin changed without launch");
    chk_pflash_both:
        assert property ($changed(pflash_margin) |->
            eeprom_margin == pflash_margin)
        else $error("pflash margin not applied to eeprom");
    chk_code_range:
        assert property (pflash_margin <= 3'h4 && eeprom_margin <= 3'h4)
        else $error("margin code out of range");
    chk_field_special:
        assert property ($changed(eeprom_margin) && eeprom_margin > 3'h2
            |-> $past(special_mode, 2))
        else $error("field margin outside special mode");
    chk_cfg_secure:
        assert property (cfg_op_req |-> unsecured)
        else $error("sector op while secured");
    chk_cfg_single:
        assert property (cfg_op_req |=> !cfg_op_req)
        else $error("sector op pulse too long");

    cover property ($rose(unsecured));
    cover property ($changed(eeprom_margin) && eeprom_margin == 3'h4);
    cover property (cfg_op_req);
endmodule : fbu_flash_sec_monitor

bind fbu_flash_sec fbu_flash_sec_monitor u_mon (.sys_clk(sys_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .special_mode(special_mode),
    .security_state(security_state), .unsecured(unsecured),
    .read_data_invalid(read_data_invalid), .pflash_margin(pflash_margin),
    .eeprom_margin(eeprom_margin), .cfg_op_req(cfg_op_req));

// ---- fbu_flash_sec_tb.sv ----
// self-checking bench for the flash security and margin command block
module fbu_flash_sec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_ST = fbu_pkg::OFS_STATUS;
    localparam logic [7:0] A_PROT = fbu_pkg::OFS_PROTECTION;
    localparam logic [7:0] A_SEC = fbu_pkg::OFS_SECURITY;
    localparam logic [7:0] A_MG = fbu_pkg::OFS_MARGIN;
    localparam logic [7:0] UM = fbu_pkg::OP_USER_MARGIN;
    localparam logic [7:0] FM = fbu_pkg::OP_FIELD_MARGIN;
    logic sys_clk, rst_n, reg_wr, reg_rd, special_mode, unsecured;
    logic read_data_invalid, cfg_op_req, cfg_op_erase;
    logic [7:0] reg_addr, nv_security_byte;
    logic [15:0] reg_wdata, reg_rdata, cfg_op_data, d;
    logic [63:0] nv_backdoor_keys;
    logic [1:0] security_state;
    logic [2:0] pflash_margin, eeprom_margin;
    int failures = 0;
    int check_count = 0;
    int pulses = 0;

    fbu_flash_sec u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
        .nv_security_byte(nv_security_byte),
        .nv_backdoor_keys(nv_backdoor_keys), .security_state(security_state),
        .unsecured(unsecured), .read_data_invalid(read_data_invalid),
        .pflash_margin(pflash_margin), .eeprom_margin(eeprom_margin),
        .cfg_op_req(cfg_op_req), .cfg_op_erase(cfg_op_erase),
        .cfg_op_data(cfg_op_data));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) if (cfg_op_req === 1'b1) pulses++;

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge sys_clk);
    endtask : rd

    task automatic wait_done;
        for (int i = 0; i < 12; i++) begin
            rd(A_ST);
            if (d[7] === 1'b1) break;
        end
        chk({15'h0000, d[7]}, 16'h0001);
    endtask : wait_done

    task automatic cmd(input logic [7:0] op, input logic [1:0] blk,
        input int n, input logic [15:0] w0, w1, w2, w3,
        input logic [2:0] last);
        logic [15:0] w[4];
        w = '{w0, w1, w2, w3};
        wr(fbu_pkg::OFS_PARAM_INDEX, 16'h0000);
        wr(fbu_pkg::OFS_PARAM_WORD, {op, 6'h00, blk});
        for (int i = 0; i < n; i++) begin
            wr(fbu_pkg::OFS_PARAM_INDEX, 16'(i + 1));
            wr(fbu_pkg::OFS_PARAM_WORD, w[i]);
        end
        wr(fbu_pkg::OFS_PARAM_INDEX, {13'h0000, last});
        wr(A_ST, 16'h0080);
    endtask : cmd

    task automatic mcmd(input logic [7:0] op, input logic [1:0] blk,
        input logic [15:0] code, input logic [2:0] last, input logic err,
        input logic [2:0] pf, input logic [2:0] ee);
        cmd(op, blk, 1, code, 16'h0000, 16'h0000, 16'h0000, last);
        wait_done();
        chk({15'h0000, d[5]}, {15'h0000, err});
        chk({13'h0000, pflash_margin}, {13'h0000, pf});
        chk({13'h0000, eeprom_margin}, {13'h0000, ee});
        if (err) wr(A_ST, 16'h0030);
    endtask : mcmd

    task automatic vkey(input logic [15:0] k0, input logic inv,
        input logic err, input logic [1:0] st);
        cmd(fbu_pkg::OP_VERIFY_KEY, 2'h0, 4, k0, 16'h2222, 16'h3333,
            16'h4444, 3'h4);
        @(negedge sys_clk);
        chk({15'h0000, read_data_invalid}, {15'h0000, inv});
        @(posedge sys_clk);
        wait_done();
        chk({15'h0000, d[5]}, {15'h0000, err});
        chk({14'h0000, security_state}, {14'h0000, st});
        chk({15'h0000, unsecured}, {15'h0000, st == 2'h2});
        if (err) wr(A_ST, 16'h0030);
    endtask : vkey

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : do_reset

    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, special_mode} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        nv_security_byte = 8'h80;
        nv_backdoor_keys = 64'h4444_3333_2222_1111;
        do_reset();
        rd(A_PROT);
        chk(d, 16'h00FF);
        rd(A_SEC);
        chk(d, 16'h0080);
        rd(8'h18);
        chk(d, 16'h0000);
        wr(A_PROT, 16'h005A);
        $display("test reset values done");
        for (int c = 0; c < 3; c++) begin
            mcmd(UM, 2'h1, 16'(c), 3'h1, 1'b0, 3'h0, 3'(c));
        end
        mcmd(UM, 2'h0, 16'h0002, 3'h1, 1'b0, 3'h2, 3'h2);
        mcmd(UM, 2'h0, 16'h0003, 3'h1, 1'b1, 3'h2, 3'h2);
        mcmd(UM, 2'h2, 16'h0001, 3'h1, 1'b1, 3'h2, 3'h2);
        mcmd(UM, 2'h1, 16'h0001, 3'h2, 1'b1, 3'h2, 3'h2);
        mcmd(FM, 2'h1, 16'h0003, 3'h1, 1'b1, 3'h2, 3'h2);
        special_mode <= 1'b1;
        for (int c = 0; c < 5; c++) begin
            mcmd(FM, 2'h1, 16'(c), 3'h1, 1'b0, 3'h2, 3'(c));
        end
        mcmd(FM, 2'h0, 16'h0004, 3'h1, 1'b0, 3'h4, 3'h4);
        mcmd(FM, 2'h0, 16'h0005, 3'h1, 1'b1, 3'h4, 3'h4);
        mcmd(FM, 2'h3, 16'h0001, 3'h1, 1'b1, 3'h4, 3'h4);
        mcmd(FM, 2'h0, 16'h0001, 3'h0, 1'b1, 3'h4, 3'h4);
        $display("test margin commands done");
        cmd(fbu_pkg::OP_ERASE_CFG, 2'h0, 1, 16'h0, 16'h0, 16'h0, 16'h0, 3'h1);
        wait_done();
        chk({15'h0000, d[4]}, 16'h0001);
        chk(16'(pulses), 16'h0000);
        wr(A_ST, 16'h0030);
        vkey(16'h1111, 1'b1, 1'b0, 2'h2);
        rd(A_SEC);
        chk(d, 16'h0082);
        rd(A_PROT);
        chk(d, 16'h005A);
        rd(A_MG);
        chk(d, 16'h0044);
        cmd(fbu_pkg::OP_ERASE_CFG, 2'h0, 1, 16'h0, 16'h0, 16'h0, 16'h0, 3'h1);
        wait_done();
        chk({15'h0000, cfg_op_erase}, 16'h0001);
        cmd(fbu_pkg::OP_PROGRAM_CFG, 2'h0, 1, 16'hFFFE, 16'h0, 16'h0, 16'h0,
            3'h1);
        wait_done();
        chk({15'h0000, cfg_op_erase}, 16'h0000);
        chk(cfg_op_data, 16'hFFFE);
        chk(16'(pulses), 16'h0002);
        $display("test unlock done");
        do_reset();
        rd(A_MG);
        chk(d, 16'h0000);
        vkey(16'h1112, 1'b1, 1'b1, 2'h0);
        rd(A_MG);
        chk(d, 16'h0100);
        vkey(16'h1111, 1'b0, 1'b1, 2'h0);
        do_reset();
        vkey(16'h1111, 1'b1, 1'b0, 2'h2);
        nv_security_byte <= 8'h40;
        do_reset();
        vkey(16'h1111, 1'b0, 1'b1, 2'h0);
        nv_security_byte <= 8'h80;
        nv_backdoor_keys <= 64'h4444_3333_2222_0000;
        do_reset();
        vkey(16'h0000, 1'b1, 1'b1, 2'h0);
        $display("test lockout done");
        complete_run();
    end

    initial begin
        repeat (6000) @(posedge sys_clk);
        failures++;
        complete_run();
    end
endmodule : fbu_flash_sec_tb
